// *** logic/bps_pkg.sv ***
`default_nettype none
package bps_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // Least time from the first data strobe falling to any acknowledge
  localparam int ACK_MIN_NS = 30;
  localparam int ACK_MIN_CYC = (ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest gap between the two data strobes; observers wait it out in full
  localparam int DSB_MAX_NS = 20;
  localparam int DSB_WAIT_CYC = (DSB_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus timer period, local source of the error acknowledge
  localparam int BUS_TIMEOUT_NS = 8000;
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  typedef struct packed {
    logic as_n;
    logic [1:0] ds_n;
    logic write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bps_bus_in_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic data_oe;
    logic dtack_n;
    logic dtack_oe;
    logic berr_n;
    logic berr_oe;
  } bps_bus_out_t;

  typedef struct packed {
    logic write;
    logic [1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bps_req_t;

  typedef enum logic [2:0] {
    BPS_IDLE = 3'h0,
    BPS_SKEW = 3'h1,
    BPS_BUSY = 3'h3,
    BPS_DATA = 3'h2,
    BPS_ACK  = 3'h6,
    BPS_DROP = 3'h7
  } bps_state_t;
endpackage
`default_nettype wire

// *** logic/bps_slave.sv ***
// Behaviour
// - On reads, data drivers stay off until the first data strobe is seen low.
// - On reads, valid data is on the lines no later than the acknowledge.
// - An error acknowledge needs no data driven before it.
// - Acknowledge or error waits a counted least time after the first strobe falls.
// - On reads, data stays unchanged after acknowledge until the first strobe rises.
// - Acknowledge or error is held until both data strobes are seen high.
// - On reads, data drivers go off before acknowledge or error is released.
// - A strobe seen before the address strobe still belongs to the new cycle.
`default_nettype none
module bps_slave #(
  parameter int TIMEOUT_CYC = bps_pkg::BUS_TIMEOUT_CYC
) (
  input wire logic i_clk,                      // 250 MHz local clock
  input wire logic i_rst_n,                    // Asynchronous reset, active low
  input wire bps_pkg::bps_bus_in_t i_bus,      // Backplane pins, asynchronous
  output bps_pkg::bps_bus_out_t o_bus,         // Backplane drivers and enables
  output logic o_req_valid,                    // One-cycle pulse: new transfer
  output bps_pkg::bps_req_t o_req,             // Transfer details, held until next
  input wire logic i_rsp_valid,                // Local answer pulse
  input wire logic i_rsp_err,                  // Answer with error acknowledge
  input wire logic [bps_pkg::DATA_W-1:0] i_rsp_data // Read data with answer
);
  import bps_pkg::*;

  if (TIMEOUT_CYC <= ACK_MIN_CYC || TIMEOUT_CYC >= (1 << CNT_W) - 1) begin : g_chk
    $error("TIMEOUT_CYC out of range");
  end

  bps_bus_in_t meta;
  bps_bus_in_t sync;
  bps_state_t state;
  bps_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic lead;
  logic have_rsp;
  logic rsp_err;
  logic [DATA_W-1:0] rsp_data;
  logic [DATA_W-1:0] data_out;
  logic data_oe;
  logic dtack_oe;
  logic berr_oe;

  // Two stages on every pin before any decision is made
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '1;
      sync <= '1;
    end else begin
      meta <= i_bus;
      sync <= meta;
    end
  end

  wire as_low = !sync.as_n;
  wire any_low = !(&sync.ds_n);
  wire both_high = &sync.ds_n;
  wire lead_low = !sync.ds_n[lead];
  wire first_lead = sync.ds_n[0] ? 1'b1 : 1'b0;
  wire rsp_now = have_rsp || i_rsp_valid;
  wire err_now = have_rsp ? rsp_err : i_rsp_err;
  wire min_done = cnt >= CNT_W'(ACK_MIN_CYC - 1);
  wire timed_out = cnt >= CNT_W'(TIMEOUT_CYC - 1);
  // Decide lanes only once the trailing strobe window is over and the address strobe is seen
  wire skew_done = (cnt >= CNT_W'(DSB_WAIT_CYC - 1)) && as_low;
  wire is_read = o_req.write == 1'b0;

  always_comb begin
    next_state = state;
    case (state)
      BPS_IDLE: if (any_low) next_state = BPS_SKEW;
      BPS_SKEW: begin
        if (!lead_low) next_state = BPS_IDLE;
        else if (skew_done) next_state = BPS_BUSY;
      end
      BPS_BUSY: begin
        // Timer error is taken at once; a normal answer waits the least time
        if (timed_out || (rsp_now && err_now && min_done)) next_state = BPS_ACK;
        else if (rsp_now && min_done) next_state = is_read ? BPS_DATA : BPS_ACK;
      end
      BPS_DATA: next_state = BPS_ACK;
      BPS_ACK: if (both_high) next_state = BPS_DROP;
      BPS_DROP: next_state = BPS_IDLE;
      default: next_state = BPS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= BPS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Cycles since the leading strobe fell; saturates so a stuck cycle cannot wrap
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= '0;
    end else if (state == BPS_IDLE) begin
      cnt <= '0;
    end else if (!(&cnt)) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lead <= 1'b0;
    end else if (state == BPS_IDLE && any_low) begin
      lead <= first_lead;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_req_valid <= 1'b0;
      o_req <= '0;
    end else begin
      o_req_valid <= state == BPS_SKEW && next_state == BPS_BUSY;
      if (state == BPS_SKEW && next_state == BPS_BUSY) begin
        o_req.write <= !sync.write_n;
        o_req.lanes <= ~sync.ds_n;
        o_req.addr <= sync.addr;
        o_req.wdata <= sync.data;
      end
    end
  end

  // An answer given early is kept until the least time has passed
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      have_rsp <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= '0;
    end else if (state != BPS_BUSY) begin
      have_rsp <= 1'b0;
    end else if (i_rsp_valid && !have_rsp) begin
      have_rsp <= 1'b1;
      rsp_err <= i_rsp_err;
      rsp_data <= i_rsp_data;
    end
  end

  wire go_data = state == BPS_BUSY && next_state == BPS_DATA;
  wire go_ack = next_state == BPS_ACK && state != BPS_ACK;
  wire ack_berr = timed_out || err_now;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_out <= '0;
      data_oe <= 1'b0;
      dtack_oe <= 1'b0;
      berr_oe <= 1'b0;
    end else begin
      if (go_data) begin
        data_out <= have_rsp ? rsp_data : i_rsp_data;
        data_oe <= 1'b1;
      end else if (next_state == BPS_DROP || next_state == BPS_IDLE) begin
        data_oe <= 1'b0;
      end
      if (go_ack) begin
        dtack_oe <= state == BPS_DATA || (state == BPS_BUSY && !ack_berr);
        berr_oe <= state == BPS_BUSY && ack_berr;
      end else if (state == BPS_DROP) begin
        dtack_oe <= 1'b0;
        berr_oe <= 1'b0;
      end
    end
  end

  assign o_bus.data = data_out;
  assign o_bus.data_oe = data_oe;
  assign o_bus.dtack_n = 1'b0;
  assign o_bus.dtack_oe = dtack_oe;
  assign o_bus.berr_n = 1'b0;
  assign o_bus.berr_oe = berr_oe;

  wire ack_any = dtack_oe || berr_oe;

  property p_data_after_strobe;
    @(posedge i_clk) disable iff (!i_rst_n) $rose(data_oe) |-> $past(lead_low) && !both_high;
  endproperty
  a_data_after_strobe: assert property (p_data_after_strobe) else $error("data driven before strobe");

  property p_data_before_ack;
    @(posedge i_clk) disable iff (!i_rst_n) $rose(dtack_oe) && is_read |-> data_oe && $past(data_oe);
  endproperty
  a_data_before_ack: assert property (p_data_before_ack) else $error("read ack without data");

  property p_berr_no_data;
    @(posedge i_clk) disable iff (!i_rst_n) $rose(berr_oe) |-> !data_oe && !dtack_oe;
  endproperty
  a_berr_no_data: assert property (p_berr_no_data) else $error("error ack with data or dtack");

  property p_min_wait;
    @(posedge i_clk) disable iff (!i_rst_n) $rose(ack_any) |-> cnt >= CNT_W'(ACK_MIN_CYC);
  endproperty
  a_min_wait: assert property (p_min_wait) else $error("acknowledge too early");

  property p_data_stable;
    @(posedge i_clk) disable iff (!i_rst_n) dtack_oe && data_oe ##1 data_oe |-> $stable(data_out);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("read data changed under ack");

  property p_hold_ack;
    @(posedge i_clk) disable iff (!i_rst_n) ack_any && !both_high |=> ack_any;
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("ack released with strobe low");

  property p_release_order;
    @(posedge i_clk) disable iff (!i_rst_n) $fell(ack_any) |-> !data_oe && !$past(data_oe);
  endproperty
  a_release_order: assert property (p_release_order) else $error("ack released before data");

  property p_req_with_as;
    @(posedge i_clk) disable iff (!i_rst_n) o_req_valid |-> $past(as_low) && o_req.addr == $past(sync.addr, 1);
  endproperty
  a_req_with_as: assert property (p_req_with_as) else $error("request without address strobe");

  property p_timeout_berr;
    @(posedge i_clk) disable iff (!i_rst_n) state == BPS_BUSY && timed_out |=> berr_oe;
  endproperty
  a_timeout_berr: assert property (p_timeout_berr) else $error("no error ack on timeout");

  c_read_ack: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(dtack_oe) && is_read);
  c_write_ack: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(dtack_oe) && !is_read);
  c_berr: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(berr_oe));
  c_two_lanes: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_req_valid && &o_req.lanes);
endmodule
`default_nettype wire

// *** bench/bps_master.sv ***
`default_nettype none
module bps_master import bps_pkg::*; (
  input wire logic i_clk, // Local clock
  input wire bps_bus_out_t i_slv, // Slave drivers
  output bps_bus_in_t o_bus, // Resolved pins
  output int o_wait, // Cycles from strobe to ack
  output logic [31:0] o_rd, // Data seen at ack
  output logic o_held // Ack held while strobes low
);
  timeunit 1ns;
  timeprecision 1ps;
  bps_bus_in_t drv;
  wire logic ack = i_slv.dtack_oe | i_slv.berr_oe;
  always_comb begin
    o_bus = drv;
    if (i_slv.data_oe) begin
      o_bus.data = i_slv.data;
    end
  end
  initial begin
    drv = '1;
    o_held = 1'b1;
    o_wait = 0;
    o_rd = '0;
  end
  task automatic xfer(input logic wr, input logic [1:0] ln, input logic [31:0] a, input logic [31:0] d,
      input logic late_as, input logic quit);
    @(negedge i_clk);
    drv.write_n = ~wr;
    drv.addr = a;
    drv.data = wr ? d : ~drv.data;
    drv.ds_n = ~ln;
    drv.as_n = late_as;
    @(negedge i_clk);
    drv.as_n = 1'b0;
    o_wait = 1;
    // Judged per transfer so one bad cycle is not blamed on the next
    o_held = 1'b1;
    if (quit) begin
      repeat (2) @(negedge i_clk);
    end
    while (!quit && !ack && o_wait < 200) begin
      @(posedge i_clk);
      o_wait++;
    end
    o_rd = o_bus.data;
    repeat (quit ? 0 : 3) begin
      @(negedge i_clk);
      o_held &= ack;
    end
    @(negedge i_clk);
    drv.ds_n = 2'b11;
    drv.as_n = 1'b1;
    // Released lines flip so stale data cannot pass for a match
    drv.data = ~drv.data;
    for (int i = 0; i < 20 && ack; i++) @(negedge i_clk);
    repeat (4) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// *** bench/bps_slave_test.sv ***
`default_nettype none
module bps_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bps_pkg::*;
  localparam int TO = 40;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_rsp_valid = 1'b0, i_rsp_err = 1'b0;
  logic [31:0] i_rsp_data = '0, rsp_d = '0, rdat;
  logic rsp_on = 1'b0, rsp_e = 1'b0, rd = 1'b0, prev_ack = 1'b0, held, o_req_valid;
  logic [2:0] kinds = '0;
  int mismatches = 0, checked = 0, reqs = 0, bad = 0, wt;
  bps_bus_in_t bus;
  bps_bus_out_t drv;
  bps_req_t o_req;
  bps_slave #(.TIMEOUT_CYC(TO)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_bus(drv),
    .o_req_valid(o_req_valid), .o_req(o_req), .i_rsp_valid(i_rsp_valid), .i_rsp_err(i_rsp_err),
    .i_rsp_data(i_rsp_data));
  bps_master m (.i_clk(i_clk), .i_slv(drv), .o_bus(bus), .o_wait(wt), .o_rd(rdat), .o_held(held));
  wire logic ack = drv.dtack_oe | drv.berr_oe;
  initial forever #2 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    i_rsp_valid <= 1'b0;
    if (rsp_on && o_req_valid) begin
      i_rsp_valid <= 1'b1;
      i_rsp_err <= rsp_e;
      i_rsp_data <= rsp_d;
    end
  end
  always @(posedge i_clk) begin
    reqs += int'(o_req_valid === 1'b1);
    kinds |= {drv.data_oe, drv.berr_oe, drv.dtack_oe};
    if (drv.data_oe && !ack && bus.ds_n == 2'b11) bad++;
    if (rd && drv.dtack_oe && !prev_ack && !drv.data_oe) bad++;
    if (drv.dtack_oe && prev_ack && drv.data_oe && drv.data !== rsp_d) bad++;
    if (prev_ack && !ack && drv.data_oe) bad++;
    // Enabled acknowledge lines must pull low, never high
    if (drv.dtack_n !== 1'b0 || drv.berr_n !== 1'b0) bad++;
    prev_ack <= ack;
  end
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input logic wr, input logic [1:0] ln, input logic [31:0] a, input logic [31:0] d,
      input logic late, input logic quit, input logic on, input logic e);
    rsp_on = on;
    rsp_e = e;
    rsp_d = d;
    rd = ~wr;
    reqs = 0;
    bad = 0;
    kinds = '0;
    m.xfer(wr, ln, a, d, late, quit);
  endtask
  task automatic t_read();
    run(1'b0, 2'b11, 32'h1000_0040, 32'ha5c3_0f96, 1'b0, 1'b0, 1'b1, 1'b0);
    check("req", 32'(reqs), 32'h1);
    check("lanes", 32'(o_req.lanes), 32'h3);
    check("write", 32'(o_req.write), 32'h0);
    check("addr", o_req.addr, 32'h1000_0040);
    check("rdata", rdat, 32'ha5c3_0f96);
    check("kinds", 32'(kinds), 32'h5);
    check("order", 32'(bad), 32'h0);
    check("min_wait", 32'(wt >= ACK_MIN_CYC + 2), 32'h1);
    check("held", 32'(held), 32'h1);
  endtask
  task automatic t_write_skew();
    run(1'b1, 2'b10, 32'h2000_0104, 32'h1234_abcd, 1'b1, 1'b0, 1'b1, 1'b0);
    check("req", 32'(reqs), 32'h1);
    check("addr", o_req.addr, 32'h2000_0104);
    check("write", 32'(o_req.write), 32'h1);
    check("lanes", 32'(o_req.lanes), 32'h2);
    check("wdata", o_req.wdata, 32'h1234_abcd);
    check("kinds", 32'(kinds), 32'h1);
    check("held", 32'(held), 32'h1);
  endtask
  task automatic t_error();
    run(1'b0, 2'b01, 32'h3000_0008, 32'h0f0f_0f0f, 1'b0, 1'b0, 1'b1, 1'b1);
    check("kinds", 32'(kinds), 32'h2);
    check("min_wait", 32'(wt >= ACK_MIN_CYC + 2), 32'h1);
    check("order", 32'(bad), 32'h0);
  endtask
  task automatic t_timeout();
    run(1'b0, 2'b11, 32'h4000_0010, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    check("kinds", 32'(kinds), 32'h2);
    check("timer", 32'(wt >= TO && wt <= 2 * TO), 32'h1);
    check("held", 32'(held), 32'h1);
  endtask
  task automatic t_abort();
    run(1'b0, 2'b01, 32'h5000_0020, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    check("req", 32'(reqs), 32'h0);
    check("kinds", 32'(kinds), 32'h0);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_read();
    t_write_skew();
    t_error();
    t_timeout();
    t_abort();
    t_read();
    final_report();
  end
  initial begin
    // Six transfers need well under a thousand cycles
    #40000;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
